// ---- verilog/dpg_pkg.sv ----
// Package for the dual port GPIO block: register offsets, resets, fields.
// Assumes a plain address/strobe register port with 8-bit data.
package dpg_pkg;
    localparam int          DPG_ADDR_W        = 8;
    localparam int          DPG_DATA_W        = 8;
    localparam int          DPG_A_W           = 5;
    localparam int          DPG_B_W           = 8;
    localparam logic [7:0]  DPG_OFF_A_DATA    = 8'h05;
    localparam logic [7:0]  DPG_OFF_B_DATA    = 8'h06;
    localparam logic [7:0]  DPG_OFF_INTCTL    = 8'h0B;
    localparam logic [7:0]  DPG_OFF_CMPCTL    = 8'h1F;
    localparam logic [7:0]  DPG_OFF_OPTION    = 8'h81;
    localparam logic [7:0]  DPG_OFF_A_DIR     = 8'h85;
    localparam logic [7:0]  DPG_OFF_B_DIR     = 8'h86;
    localparam logic [7:0]  DPG_OFF_INTCTL_HI = 8'h8B;
    localparam logic [7:0]  DPG_RST_OPTION    = 8'hFF;
    localparam logic [4:0]  DPG_RST_A_DIR     = 5'h1F;
    localparam logic [7:0]  DPG_RST_B_DIR     = 8'hFF;
    localparam logic [2:0]  DPG_RST_CMPMODE   = 3'h0;
    localparam int          DPG_BIT_PUDIS     = 7;
    localparam int          DPG_BIT_GIE       = 7;
    localparam int          DPG_BIT_CIE       = 3;
    localparam int          DPG_BIT_CIF       = 0;
    localparam int          DPG_BIT_CIS       = 3;
    localparam int          DPG_CHG_LO        = 4;
    localparam int          DPG_PIN_VREF      = 2;
    localparam int          DPG_PIN_C1OUT     = 3;
    localparam int          DPG_PIN_OD        = 4;
    // Comparator modes
    localparam logic [2:0]  DPG_CM_RESET      = 3'h0;
    localparam logic [2:0]  DPG_CM_TWO_OUT    = 3'h6;
    localparam logic [2:0]  DPG_CM_OFF        = 3'h7;
    localparam logic [2:0]  DPG_CM_MUX_ONE    = 3'h1;
    localparam logic [2:0]  DPG_CM_MUX_TWO    = 3'h2;
    localparam logic [2:0]  DPG_CM_ONE_PAIR   = 3'h5;
    // Analog pin maps, one bit per first-port pin
    localparam logic [4:0]  DPG_AN_NONE       = 5'h00;
    localparam logic [4:0]  DPG_AN_PAIR       = 5'h03;
    localparam logic [4:0]  DPG_AN_LOW3       = 5'h07;
    localparam logic [4:0]  DPG_AN_HIGH3      = 5'h0E;
    localparam logic [4:0]  DPG_AN_ALL        = 5'h0F;
endpackage

// ---- verilog/dpg_gpio.sv ----
// Dual port GPIO with change detection on the upper second-port pins.
// Assumes pins are synchronous to i_clk_sys and comparator results are
// provided by an outside comparator block.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - First port has five latch bits, directions
// - Direction one floats pin, zero drives latch
// - Data read returns pins, write hits latch
// - Writes modify sampled pins, then store
// - Analog-selected first-port pins read zero
// - Reset makes all first-port pins inputs
// - Direction still gates drivers in analog use
// - Comparator outputs drive only if directions clear
// - Pin 4 open drain, feeds timer clock
// - Upper three first-port bits read zero
// - Second port eight bits, same direction coding
// - Active-low bit enables all pull-ups
// - Pull-up off when pin is output
// - Pull-ups disabled after reset
// - Only upper input pins detect change
// - Compare against last access, OR sets flag
// - Change detection can wake from sleep
// - Mismatch keeps setting flag until port access
// - Writes land and reads sample at cycle end
// - Interrupt needs change enable and global enable
// - Flag sets regardless of enables
module dpg_gpio
    import dpg_pkg::*;
(
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst_n,
    input  wire logic [DPG_ADDR_W-1:0] i_addr,
    input  wire logic [DPG_DATA_W-1:0] i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [DPG_DATA_W-1:0] o_rdata,
    input  wire logic [DPG_A_W-1:0]    i_a_pin,
    output logic      [DPG_A_W-1:0]    o_a_pin,
    output logic      [DPG_A_W-1:0]    o_a_pin_oe_n,
    input  wire logic [DPG_B_W-1:0]    i_b_pin,
    output logic      [DPG_B_W-1:0]    o_b_pin,
    output logic      [DPG_B_W-1:0]    o_b_pin_oe_n,
    output logic      [DPG_B_W-1:0]    o_b_pullup_en,
    input  wire logic [1:0]            i_cmp_result,
    input  wire logic                  i_vref_out_en,
    output logic                       o_timer_ext_clock_in,
    output logic                       o_change_irq,
    output logic                       o_change_wake
);

    // Widths are tied to the 8-bit register layout
    if (DPG_A_W != 5 || DPG_B_W != 8 || DPG_DATA_W != 8) begin : g_bad_width
        $error("dpg_gpio: port widths are fixed by the register layout");
    end

    logic [DPG_A_W-1:0] a_latch;
    logic [DPG_A_W-1:0] port_a_direction;
    logic [DPG_B_W-1:0] b_latch;
    logic [DPG_B_W-1:0] port_b_direction;
    logic [7:0]         option_config;
    logic [7:0]         interrupt_control_reg;
    logic [3:0]         comparator_control;
    logic [3:0]         b_read_snap;
    logic [7:0]         rdata_q;

    // Address decode
    wire sel_a   = (i_addr == DPG_OFF_A_DATA);
    wire sel_b   = (i_addr == DPG_OFF_B_DATA);
    wire sel_opt = (i_addr == DPG_OFF_OPTION);
    wire sel_ad  = (i_addr == DPG_OFF_A_DIR);
    wire sel_bd  = (i_addr == DPG_OFF_B_DIR);
    wire sel_ic  = (i_addr == DPG_OFF_INTCTL) || (i_addr == DPG_OFF_INTCTL_HI);
    wire sel_cm  = (i_addr == DPG_OFF_CMPCTL);

    // Write enables; strobe and decode meet once here
    wire wr_a    = i_wr & sel_a;
    wire wr_b    = i_wr & sel_b;
    wire wr_opt  = i_wr & sel_opt;
    wire wr_ad   = i_wr & sel_ad;
    wire wr_bd   = i_wr & sel_bd;
    wire wr_ic   = i_wr & sel_ic;
    wire wr_cm   = i_wr & sel_cm;

    // Analog input selection per comparator mode
    wire [2:0] cm_mode  = comparator_control[2:0];
    wire       cm_cis   = comparator_control[DPG_BIT_CIS];
    logic [DPG_A_W-1:0] analog_sel;
    always_comb begin
        case (cm_mode)
            DPG_CM_OFF:      analog_sel = DPG_AN_NONE;
            DPG_CM_ONE_PAIR: analog_sel = DPG_AN_PAIR;
            DPG_CM_MUX_ONE:  analog_sel = cm_cis ? DPG_AN_HIGH3 : DPG_AN_LOW3;
            DPG_CM_MUX_TWO:  analog_sel = DPG_AN_ALL;
            default:         analog_sel = DPG_AN_ALL;
        endcase
    end

    wire [DPG_A_W-1:0] a_read  = i_a_pin & ~analog_sel;
    wire [7:0]         a_read8 = {3'h0, a_read};
    wire [7:0]         b_read8 = i_b_pin;

    // Read-modify-write: incoming data is the modified value of sampled pins
    wire [DPG_A_W-1:0] next_a_latch = i_wdata[DPG_A_W-1:0];

    // Change detection
    wire [3:0] b_hi_in   = i_b_pin[DPG_B_W-1:DPG_CHG_LO];
    wire [3:0] b_hi_dirs = port_b_direction[DPG_B_W-1:DPG_CHG_LO];
    wire [3:0] mismatch  = (b_hi_in ^ b_read_snap) & b_hi_dirs;
    wire       chg_evt   = |mismatch;
    wire       b_access  = sel_b & (i_rd | i_wr);

    wire [7:0] next_intctl_w = i_wdata;
    wire       next_flag = chg_evt | (wr_ic ? next_intctl_w[DPG_BIT_CIF]
                                            : interrupt_control_reg[DPG_BIT_CIF]);

    // Read data mux
    logic [7:0] next_rdata;
    always_comb begin
        if (sel_a) begin
            next_rdata = a_read8;
        end else if (sel_b) begin
            next_rdata = b_read8;
        end else if (sel_opt) begin
            next_rdata = option_config;
        end else if (sel_ad) begin
            next_rdata = {3'h0, port_a_direction};
        end else if (sel_bd) begin
            next_rdata = port_b_direction;
        end else if (sel_ic) begin
            next_rdata = interrupt_control_reg;
        end else if (sel_cm) begin
            next_rdata = {i_cmp_result, 2'h0, comparator_control};
        end else begin
            next_rdata = 8'h00;
        end
    end

    // Registers; a write lands at the edge closing its cycle
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            a_latch               <= 5'h00;
            b_latch               <= 8'h00;
            port_a_direction      <= DPG_RST_A_DIR;
            port_b_direction      <= DPG_RST_B_DIR;
            option_config         <= DPG_RST_OPTION;
            comparator_control    <= {1'b0, DPG_RST_CMPMODE};
            interrupt_control_reg <= 8'h00;
        end else begin
            if (wr_a) a_latch <= next_a_latch;
            if (wr_b) b_latch <= i_wdata;
            if (wr_ad) port_a_direction <= i_wdata[DPG_A_W-1:0];
            if (wr_bd) port_b_direction <= i_wdata;
            if (wr_opt) option_config <= i_wdata;
            if (wr_cm) comparator_control <= i_wdata[3:0];
            if (wr_ic) interrupt_control_reg <= next_intctl_w;
            // Set wins over a same-cycle clear
            interrupt_control_reg[DPG_BIT_CIF] <= next_flag;
        end
    end

    // Snapshot of the upper pins on every second-port access
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            b_read_snap <= 4'h0;
        end else if (b_access) begin
            b_read_snap <= b_hi_in;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= 8'h00;
        end else if (i_rd) begin
            rdata_q <= next_rdata;
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign o_rdata = rdata_q;

    // Pin drive; comparator outputs need both directions cleared
    wire cmp_out_mode = (cm_mode == DPG_CM_TWO_OUT) &&
                        (port_a_direction[DPG_PIN_OD:DPG_PIN_C1OUT] == 2'b00);
    logic [DPG_A_W-1:0] next_a_val;
    logic [DPG_A_W-1:0] next_a_oe_n;
    always_comb begin
        next_a_val  = a_latch;
        next_a_oe_n = port_a_direction;
        if (cmp_out_mode) begin
            next_a_val[DPG_PIN_C1OUT] = i_cmp_result[0];
            next_a_val[DPG_PIN_OD]    = i_cmp_result[1];
        end
        if (i_vref_out_en) begin
            next_a_oe_n[DPG_PIN_VREF] = 1'b1;
        end
        // Open drain: only low is driven
        next_a_oe_n[DPG_PIN_OD] = next_a_oe_n[DPG_PIN_OD] | next_a_val[DPG_PIN_OD];
        next_a_val[DPG_PIN_OD]  = 1'b0;
    end

    wire [DPG_B_W-1:0] next_pullup = port_b_direction &
                                     {DPG_B_W{~option_config[DPG_BIT_PUDIS]}};
    wire next_irq = interrupt_control_reg[DPG_BIT_CIF] &
                    interrupt_control_reg[DPG_BIT_CIE] &
                    interrupt_control_reg[DPG_BIT_GIE];

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_a_pin              <= 5'h00;
            o_a_pin_oe_n         <= DPG_RST_A_DIR;
            o_b_pin              <= 8'h00;
            o_b_pin_oe_n         <= DPG_RST_B_DIR;
            o_b_pullup_en        <= 8'h00;
            o_timer_ext_clock_in <= 1'b0;
            o_change_irq         <= 1'b0;
            o_change_wake        <= 1'b0;
        end else begin
            o_a_pin              <= next_a_val;
            o_a_pin_oe_n         <= next_a_oe_n;
            o_b_pin              <= b_latch;
            o_b_pin_oe_n         <= port_b_direction;
            o_b_pullup_en        <= next_pullup;
            o_timer_ext_clock_in <= i_a_pin[DPG_PIN_OD];
            o_change_irq         <= next_irq;
            // Wake ignores the global enable, only the change enable
            o_change_wake        <= interrupt_control_reg[DPG_BIT_CIF] &
                                    interrupt_control_reg[DPG_BIT_CIE];
        end
    end

    // Checks watch internal registers as well as pins
    a_flag_set_on_mismatch: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        chg_evt |=> interrupt_control_reg[DPG_BIT_CIF])
        else $error("change flag not set after mismatch");

    a_irq_needs_enables: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_change_irq |-> $past(interrupt_control_reg[DPG_BIT_GIE] &
                               interrupt_control_reg[DPG_BIT_CIE]))
        else $error("irq without enables");

    a_pullup_off_output: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ##1 (o_b_pullup_en & ~$past(port_b_direction)) == 8'h00)
        else $error("pull-up on an output pin");

    a_a_read_analog_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_rd && sel_a) |=> (o_rdata[DPG_A_W-1:0] & $past(analog_sel)) == 5'h00)
        else $error("analog pin read nonzero");

    a_a_read_upper_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_rd && (sel_a || sel_ad)) |=> o_rdata[7:5] == 3'h0)
        else $error("upper bits nonzero");

    a_od_pin_no_high: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !o_a_pin_oe_n[DPG_PIN_OD] |-> !o_a_pin[DPG_PIN_OD])
        else $error("open-drain pin driven high");

    a_b_read_pins: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_rd && sel_b) |=> o_rdata == $past(i_b_pin))
        else $error("port b read not pins");

    a_snap_ends_mismatch: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        b_access |=> b_read_snap == $past(b_hi_in))
        else $error("snapshot not taken");

    // Pin 2 left out: the reference output may float it
    a_a_dir_drive: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ##1 (o_a_pin_oe_n[DPG_PIN_VREF-1:0] == $past(port_a_direction[DPG_PIN_VREF-1:0])))
        else $error("direction not applied");

    a_vref_pin_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_vref_out_en |=> o_a_pin_oe_n[DPG_PIN_VREF])
        else $error("reference pin driven");

    a_cmp_pin_dir: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ##1 (o_a_pin_oe_n[DPG_PIN_C1OUT] == $past(port_a_direction[DPG_PIN_C1OUT])))
        else $error("pin 3 direction not applied");

    a_cmp_out_gated: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !cmp_out_mode |=> o_a_pin[DPG_PIN_C1OUT] == $past(a_latch[DPG_PIN_C1OUT]))
        else $error("comparator drives without cleared directions");

    a_cmp_out_drive: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        cmp_out_mode |=> o_a_pin[DPG_PIN_C1OUT] == $past(i_cmp_result[0]))
        else $error("comparator result not on pin 3");

    a_tmr_clk_copy: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ##1 (o_timer_ext_clock_in == $past(i_a_pin[DPG_PIN_OD])))
        else $error("timer clock not pin 4");

    a_flag_clear_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (wr_ic && !i_wdata[DPG_BIT_CIF] && !chg_evt) |=> !interrupt_control_reg[DPG_BIT_CIF])
        else $error("change flag not cleared");

    a_flag_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (!chg_evt && !wr_ic) |=> $stable(interrupt_control_reg[DPG_BIT_CIF]))
        else $error("change flag moved without cause");

    a_irq_follows: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ##1 (o_change_irq == $past(interrupt_control_reg[DPG_BIT_CIF] &
                                   interrupt_control_reg[DPG_BIT_CIE] &
                                   interrupt_control_reg[DPG_BIT_GIE])))
        else $error("irq not following flag and enables");

    a_wake_follows: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ##1 (o_change_wake == $past(interrupt_control_reg[DPG_BIT_CIF] &
                                    interrupt_control_reg[DPG_BIT_CIE])))
        else $error("wake not following flag and enable");

    a_a_latch_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        wr_a |=> a_latch == $past(i_wdata[DPG_A_W-1:0]))
        else $error("first port latch not written");

    a_a_dir_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        wr_ad |=> port_a_direction == $past(i_wdata[DPG_A_W-1:0]))
        else $error("first port direction not written");

    a_b_latch_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        wr_b |=> b_latch == $past(i_wdata))
        else $error("second port latch not written");

    a_b_dir_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        wr_bd |=> port_b_direction == $past(i_wdata))
        else $error("second port direction not written");

    a_b_oe_follows: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ##1 (o_b_pin_oe_n == $past(port_b_direction)))
        else $error("second port enables not direction");

    a_b_pin_latch: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ##1 (o_b_pin == $past(b_latch)))
        else $error("second port drive not latch");

    a_rdata_idle_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !i_rd |=> o_rdata == 8'h00)
        else $error("read data outside read cycle");

    a_pullup_global_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        option_config[DPG_BIT_PUDIS] |=> o_b_pullup_en == 8'h00)
        else $error("pull-up on while disabled");

    a_out_pins_excluded: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (b_hi_dirs == 4'h0) |-> !chg_evt)
        else $error("output pin took part in change detection");

endmodule

`default_nettype wire

// ---- dv/dpg_pins.sv ----
// Pin-side model: loads and external drivers on both ports.
// Assumes active-low enables; a_pin4 driver only pulls low.
`timescale 1ns/100ps
`default_nettype none
module dpg_pins (
    input  wire logic       i_clk_sys,
    input  wire logic [4:0] i_a_drv,
    input  wire logic [4:0] i_a_oe_n,
    input  wire logic [4:0] i_a_ext,
    input  wire logic [7:0] i_b_drv,
    input  wire logic [7:0] i_b_oe_n,
    input  wire logic [7:0] i_b_pu,
    input  wire logic [7:0] i_b_ext,
    input  wire logic [7:0] i_b_ext_en,
    output logic      [4:0] o_a_lvl,
    output logic      [7:0] o_b_lvl
);
    logic [7:0] b_last;
    // Floating pins toggle so a stale level never reads as valid
    always_ff @(posedge i_clk_sys) b_last <= o_b_lvl;
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            o_a_lvl[i] = i_a_oe_n[i] ? i_a_ext[i] : i_a_drv[i];
        end
        for (int i = 0; i < 8; i++) begin
            if (!i_b_oe_n[i]) o_b_lvl[i] = i_b_drv[i];
            else if (i_b_ext_en[i]) o_b_lvl[i] = i_b_ext[i];
            else if (i_b_pu[i]) o_b_lvl[i] = 1'b1;
            else o_b_lvl[i] = ~b_last[i];
        end
    end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the dual port GPIO block.
// Assumes register reads answer one cycle after the strobe.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import dpg_pkg::*;
    logic       clk = 0, rst_n = 0, wr = 0, rd = 0, rd_d = 0, vref = 0;
    logic       tmr_clk, irq, wake;
    logic [1:0] cmp = '0;
    logic [4:0] a_ext = '0, a_pin, a_drv, a_oe_n;
    logic [7:0] addr = '0, wdata = '0, rdata, b_pin, b_drv, b_oe_n, b_pu;
    logic [7:0] b_ext = '0, b_en = 8'hFF;
    logic [31:0] r;
    logic [7:0] expq[$];
    int         num_errors = 0, n_compared = 0;
    always #25 clk = ~clk;
    dpg_gpio uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_a_pin(a_pin), .o_a_pin(a_drv),
        .o_a_pin_oe_n(a_oe_n), .i_b_pin(b_pin), .o_b_pin(b_drv), .o_b_pin_oe_n(b_oe_n),
        .o_b_pullup_en(b_pu), .i_cmp_result(cmp), .i_vref_out_en(vref),
        .o_timer_ext_clock_in(tmr_clk), .o_change_irq(irq), .o_change_wake(wake));
    dpg_pins pins (.i_clk_sys(clk), .i_a_drv(a_drv), .i_a_oe_n(a_oe_n), .i_a_ext(a_ext),
        .i_b_drv(b_drv), .i_b_oe_n(b_oe_n), .i_b_pu(b_pu), .i_b_ext(b_ext),
        .i_b_ext_en(b_en), .o_a_lvl(a_pin), .o_b_lvl(b_pin));
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
        n_compared++;
        if (g !== ex) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, ex, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] ex);
        @(posedge clk);
        expq.push_back(ex);
        addr <= a;
        rd <= 1'b1;
        wr <= 1'b0;
    endtask
    task automatic settle(input int n);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic report_and_stop();
        if (expq.size() != 0) num_errors++;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) begin
        if (rd_d) begin
            if (expq.size() == 0) begin
                num_errors++;
                $display("mismatch rdata expected none seen %h", rdata);
            end else begin
                chk("rdata", expq.pop_front(), rdata);
            end
        end
    end
    initial begin
        #(50 * 3000);
        num_errors++;
        report_and_stop();
    end
    initial begin
        r = $urandom(32'h1bdf);
        a_ext <= r[4:0];
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        settle(1);
        chk("a_oe_n", 8'h1F, {3'h0, a_oe_n});
        chk("b_oe_n", 8'hFF, b_oe_n);
        chk("pullup", 8'h00, b_pu);
        rd_reg(DPG_OFF_OPTION, DPG_RST_OPTION);
        rd_reg(DPG_OFF_A_DIR, 8'h1F);
        rd_reg(DPG_OFF_B_DIR, DPG_RST_B_DIR);
        rd_reg(DPG_OFF_A_DATA, {3'h0, r[4], 4'h0});
        wr_reg(DPG_OFF_A_DIR, 8'hE0);
        settle(3);
        chk("a_oe_n", 8'h00, {3'h0, a_oe_n});
        rd_reg(DPG_OFF_A_DIR, 8'h00);
        rd_reg(DPG_OFF_A_DATA, 8'h00);
        wr_reg(DPG_OFF_CMPCTL, {5'h0, DPG_CM_OFF});
        wr_reg(DPG_OFF_A_DATA, {4'h0, r[3:0]});
        rd_reg(DPG_OFF_A_DATA, 8'h00);
        settle(3);
        chk("a_pin", {4'h0, r[3:0]}, {3'h0, a_drv});
        rd_reg(DPG_OFF_A_DATA, {4'h0, r[3:0]});
        wr_reg(DPG_OFF_A_DATA, 8'h10);
        a_ext <= 5'h10;
        settle(3);
        chk("a_oe_n", 8'h10, {3'h0, a_oe_n});
        chk("tmr_clk", 8'h01, {7'h0, tmr_clk});
        @(posedge clk);
        vref <= 1'b1;
        cmp <= r[6:5];
        wr_reg(DPG_OFF_A_DIR, 8'h04);
        wr_reg(DPG_OFF_CMPCTL, {5'h0, DPG_CM_TWO_OUT});
        settle(3);
        chk("cmp_out", {5'h0, 1'b1, r[6:5]}, {5'h0, a_oe_n[2], a_oe_n[4], a_drv[3]});
        wr_reg(DPG_OFF_B_DIR, 8'hF0);
        wr_reg(DPG_OFF_B_DATA, r[15:8]);
        wr_reg(DPG_OFF_OPTION, 8'h7F);
        b_en <= 8'h0F;
        settle(3);
        chk("b_oe_n", 8'hF0, b_oe_n);
        chk("pullup", 8'hF0, b_pu);
        chk("b_pin", {4'hF, r[11:8]}, b_pin);
        rd_reg(DPG_OFF_B_DATA, {4'hF, r[11:8]});
        settle(2);
        wr_reg(DPG_OFF_INTCTL, 8'h00);
        settle(2);
        @(posedge clk);
        b_en <= 8'hFF;
        b_ext <= 8'h70;
        settle(4);
        rd_reg(DPG_OFF_INTCTL, 8'h01);
        wr_reg(DPG_OFF_INTCTL, 8'h08);
        settle(2);
        chk("irq_wake", 8'h01, {6'h0, irq, wake});
        wr_reg(DPG_OFF_INTCTL, 8'h88);
        settle(2);
        chk("irq_wake", 8'h03, {6'h0, irq, wake});
        rd_reg(DPG_OFF_B_DATA, {4'h7, r[11:8]});
        settle(2);
        wr_reg(DPG_OFF_INTCTL_HI, 8'h88);
        settle(2);
        chk("irq_wake", 8'h00, {6'h0, irq, wake});
        rd_reg(DPG_OFF_INTCTL, 8'h88);
        wr_reg(DPG_OFF_B_DIR, 8'hFF);
        settle(2);
        rd_reg(DPG_OFF_B_DATA, 8'h70);
        settle(2);
        @(posedge clk);
        b_ext <= 8'h7F;
        settle(4);
        chk("irq_wake", 8'h00, {6'h0, irq, wake});
        rd_reg(DPG_OFF_INTCTL, 8'h88);
        // Pin 7 turned output and driven high: must not raise the flag
        wr_reg(DPG_OFF_B_DATA, 8'h80);
        wr_reg(DPG_OFF_B_DIR, 8'h7F);
        settle(4);
        chk("b_pin7", 8'h80, b_pin & 8'h80);
        rd_reg(DPG_OFF_INTCTL, 8'h88);
        rd_reg(8'h40, 8'h00);
        settle(2);
        report_and_stop();
    end
endmodule
`default_nettype wire
